/* include/spp_pkg.sv */
package spp_pkg;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] SPP_CTRL_OFS = 5'h00;
    localparam logic [4:0] SPP_STAT_OFS = 5'h04;
    localparam logic [4:0] SPP_DATA_OFS = 5'h08;
    localparam logic [4:0] SPP_IST_OFS = 5'h0c;
    localparam logic [4:0] SPP_IMSK_OFS = 5'h10;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SPP_CTL_IE = 7;
    localparam int SPP_CTL_EN = 6;
    localparam int SPP_CTL_MSTR = 4;
    localparam int SPP_CTL_POL = 3;
    localparam int SPP_CTL_PHA = 2;
    localparam int SPP_CTL_RHI = 1;
    localparam int SPP_CTL_RLO = 0;
    localparam int SPP_ST_DONE = 7;
    localparam int SPP_ST_WRITE_COLLISION_FLAG = 6;
    localparam int SPP_ST_DBL = 0;
    localparam int SPP_EV_DONE = 0;
    localparam int SPP_EV_WRITE_COLLISION_FLAG = 1;
    localparam int SPP_EV_MODF = 2;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] SPP_CTRL_RST = 8'h00;
    localparam logic SPP_DBL_RST = 1'b0;
    localparam logic [2:0] SPP_IMSK_RST = 3'h0;
    // ------------------------------------------------------------
    // SCK half periods in core clocks (divisor / 2)
    // ------------------------------------------------------------
    localparam logic [6:0] SPP_HALF_N0 = 7'h02;
    localparam logic [6:0] SPP_HALF_N1 = 7'h08;
    localparam logic [6:0] SPP_HALF_N2 = 7'h20;
    localparam logic [6:0] SPP_HALF_N3 = 7'h40;
    localparam logic [6:0] SPP_HALF_D0 = 7'h01;
    localparam logic [6:0] SPP_HALF_D1 = 7'h04;
    localparam logic [6:0] SPP_HALF_D2 = 7'h10;
    localparam logic [6:0] SPP_HALF_D3 = 7'h20;
    localparam logic [4:0] SPP_LAST_EDGE = 5'h0f;
    typedef enum logic [1:0] {
        SPP_IDLE = 2'b01,
        SPP_SHIFT = 2'b10
    } spp_state_t;
endpackage

/* core/spp_ctrl.sv */
`timescale 1ns/1ps
// Contract
// - Phase bit 0 samples on the leading SCK edge and sets up on the trailing one; 1 the reverse.
// - The rate bits shape SCK only in master mode and do nothing in slave mode.
// - Master SCK is fosc/4,/16,/64,/128 for codes 0..3, or /2,/8,/32,/64 at double speed.
// - The transfer-done flag sets as soon as a byte transfer completes.
// - An interrupt is requested while done is set, its enable is one and global enable is on.
// - In master mode a low SS input sets the transfer-done flag.
// - Executing the matching interrupt vector clears the transfer-done flag.
// - A status read that showed done set, then any data access, clears done.
// - Writing the data register during a transfer sets the write-collision flag.
// - A status read that showed collision set, then a data access, clears both flags.
module spp_ctrl
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Interrupt
    input wire logic global_irq_en,
    input wire logic vector_ack,
    output logic irq,
    // Serial pins
    output logic sck_o,
    output logic sck_oe,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    input wire logic ss_n
);
    import spp_pkg::*;

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [4:0] adr, input logic [4:0] ofs);
        hit = (adr == ofs);
    endfunction

    function automatic logic [6:0] half_of(input logic [1:0] rate, input logic dbl);
        logic [6:0] h;
        h = SPP_HALF_N0;
        case ({dbl, rate})
            3'h0: h = SPP_HALF_N0;
            3'h1: h = SPP_HALF_N1;
            3'h2: h = SPP_HALF_N2;
            3'h3: h = SPP_HALF_N3;
            3'h4: h = SPP_HALF_D0;
            3'h5: h = SPP_HALF_D1;
            3'h6: h = SPP_HALF_D2;
            default: h = SPP_HALF_D3;
        endcase
        half_of = h;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    spp_state_t state, next_state;
    logic [7:0] ctrl, next_ctrl;
    logic dbl, next_dbl;
    logic done, next_done;
    logic write_collision_flag, next_write_collision_flag;
    logic arm_done, next_arm_done;
    logic arm_write_collision_flag, next_arm_write_collision_flag;
    logic [2:0] ist, next_ist;
    logic [2:0] imsk, next_imsk;
    logic [6:0] cnt, next_cnt;
    logic [4:0] edge_n, next_edge_n;
    logic sck_ph, next_sck_ph;
    logic [7:0] tx, next_tx;
    logic [7:0] rx, next_rx;
    logic [7:0] rxbuf, next_rxbuf;
    logic next_mosi;
    logic next_sck;
    logic next_oe;
    logic next_irq;
    logic [31:0] next_rdata;
    logic next_wait;
    logic rd, wr, data_acc, busy, start, collide, modf, tick, last, sample;
    logic [6:0] half;
    // Access takes effect only at the edge where waitrequest is low
    assign rd = avs_read & ~avs_waitrequest;
    assign wr = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign data_acc = (rd | (avs_write & ~avs_waitrequest)) & hit(avs_address, SPP_DATA_OFS);
    assign busy = (state == SPP_SHIFT);
    assign start = wr & hit(avs_address, SPP_DATA_OFS) & ~busy
                 & ctrl[SPP_CTL_EN] & ctrl[SPP_CTL_MSTR];
    assign collide = wr & hit(avs_address, SPP_DATA_OFS) & busy;
    assign modf = ctrl[SPP_CTL_EN] & ctrl[SPP_CTL_MSTR] & ~ss_n;
    assign half = half_of(ctrl[SPP_CTL_RHI:SPP_CTL_RLO], dbl);
    assign tick = busy & (cnt == 7'h00);
    assign last = tick & (edge_n == SPP_LAST_EDGE);
    // Even edge numbers are leading edges
    assign sample = ~edge_n[0] ^ ctrl[SPP_CTL_PHA];

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_state = state;
        next_ctrl = ctrl;
        next_dbl = dbl;
        next_done = done;
        next_write_collision_flag = write_collision_flag;
        next_arm_done = arm_done;
        next_arm_write_collision_flag = arm_write_collision_flag;
        next_imsk = imsk;
        next_cnt = cnt;
        next_edge_n = edge_n;
        next_sck_ph = sck_ph;
        next_tx = tx;
        next_rx = rx;
        next_rxbuf = rxbuf;
        next_mosi = mosi_o;
        next_rdata = 32'h0000_0000;

        if (wr && hit(avs_address, SPP_CTRL_OFS))
            next_ctrl = avs_writedata[7:0];
        if (wr && hit(avs_address, SPP_STAT_OFS))
            next_dbl = avs_writedata[SPP_ST_DBL];
        if (wr && hit(avs_address, SPP_IMSK_OFS))
            next_imsk = avs_writedata[2:0];

        // Shift engine: one tick per SCK half period
        if (busy)
        begin
            next_cnt = tick ? half - 7'h01 : cnt - 7'h01;
            if (tick)
            begin
                next_sck_ph = ~sck_ph;
                next_edge_n = edge_n + 5'h01;
                if (sample)
                begin
                    next_rx = {rx[6:0], miso_i};
                end
                else
                begin
                    next_mosi = tx[7];
                    next_tx = {tx[6:0], 1'b0};
                end
                if (last)
                begin
                    next_state = SPP_IDLE;
                    next_rxbuf = next_rx;
                end
            end
        end
        else if (start)
        begin
            next_state = SPP_SHIFT;
            next_cnt = half - 7'h01;
            next_edge_n = 5'h00;
            next_sck_ph = 1'b0;
            next_rx = 8'h00;
            // Phase 0 must present bit 7 before the first edge
            if (ctrl[SPP_CTL_PHA])
            begin
                next_tx = avs_writedata[7:0];
            end
            else
            begin
                next_mosi = avs_writedata[7];
                next_tx = {avs_writedata[6:0], 1'b0};
            end
        end
        // A foreign master pulls SS low: drop to slave and abort the byte
        if (modf)
        begin
            next_ctrl[SPP_CTL_MSTR] = 1'b0;
            next_state = SPP_IDLE;
            next_sck_ph = 1'b0;
        end

        // Arm the clear sequence with what the status read returned
        if (rd && hit(avs_address, SPP_STAT_OFS))
        begin
            next_arm_done = avs_readdata[SPP_ST_DONE];
            next_arm_write_collision_flag = avs_readdata[SPP_ST_WRITE_COLLISION_FLAG];
        end
        if (data_acc)
        begin
            next_arm_done = 1'b0;
            next_arm_write_collision_flag = 1'b0;
            if (arm_done || arm_write_collision_flag)
                next_done = 1'b0;
            if (arm_write_collision_flag)
                next_write_collision_flag = 1'b0;
        end
        if (vector_ack)
            next_done = 1'b0;
        // Setting wins over any clear in the same cycle
        if (last || modf)
            next_done = 1'b1;
        if (collide)
            next_write_collision_flag = 1'b1;
        next_ist = ist;
        if (wr && hit(avs_address, SPP_IST_OFS))
            next_ist = ist & ~avs_writedata[2:0];
        next_ist[SPP_EV_DONE] = next_ist[SPP_EV_DONE] | last;
        next_ist[SPP_EV_WRITE_COLLISION_FLAG] = next_ist[SPP_EV_WRITE_COLLISION_FLAG] | collide;
        next_ist[SPP_EV_MODF] = next_ist[SPP_EV_MODF] | modf;
        // Read data is launched while waitrequest is still high
        if (avs_read && avs_waitrequest)
        begin
            case (avs_address)
                SPP_CTRL_OFS: next_rdata[7:0] = ctrl;
                SPP_STAT_OFS:
                begin
                    next_rdata[SPP_ST_DONE] = done;
                    next_rdata[SPP_ST_WRITE_COLLISION_FLAG] = write_collision_flag;
                    next_rdata[SPP_ST_DBL] = dbl;
                end
                SPP_DATA_OFS: next_rdata[7:0] = rxbuf;
                SPP_IST_OFS: next_rdata[2:0] = ist;
                SPP_IMSK_OFS: next_rdata[2:0] = imsk;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
        next_wait = ~((avs_read | avs_write) & avs_waitrequest);
        next_irq = global_irq_en
                 & ((done & ctrl[SPP_CTL_IE]) | (|(ist & imsk)));
        // Slave never drives SCK, so the rate bits cannot reach the pin
        next_oe = next_ctrl[SPP_CTL_EN] & next_ctrl[SPP_CTL_MSTR];
        next_sck = next_ctrl[SPP_CTL_POL] ^ next_sck_ph;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            state <= SPP_IDLE;
            ctrl <= SPP_CTRL_RST;
            dbl <= SPP_DBL_RST;
            done <= 1'b0;
            write_collision_flag <= 1'b0;
            arm_done <= 1'b0;
            arm_write_collision_flag <= 1'b0;
            ist <= 3'h0;
            imsk <= SPP_IMSK_RST;
            cnt <= 7'h00;
            edge_n <= 5'h00;
            sck_ph <= 1'b0;
            tx <= 8'h00;
            rx <= 8'h00;
            rxbuf <= 8'h00;
            mosi_o <= 1'b0;
            sck_o <= 1'b0;
            sck_oe <= 1'b0;
            mosi_oe <= 1'b0;
            irq <= 1'b0;
            avs_readdata <= 32'h0000_0000;
            avs_waitrequest <= 1'b1;
        end
        else
        begin
            state <= next_state;
            ctrl <= next_ctrl;
            dbl <= next_dbl;
            done <= next_done;
            write_collision_flag <= next_write_collision_flag;
            arm_done <= next_arm_done;
            arm_write_collision_flag <= next_arm_write_collision_flag;
            ist <= next_ist;
            imsk <= next_imsk;
            cnt <= next_cnt;
            edge_n <= next_edge_n;
            sck_ph <= next_sck_ph;
            tx <= next_tx;
            rx <= next_rx;
            rxbuf <= next_rxbuf;
            mosi_o <= next_mosi;
            sck_o <= next_sck;
            sck_oe <= next_oe;
            mosi_oe <= next_oe;
            irq <= next_irq;
            avs_readdata <= next_rdata;
            avs_waitrequest <= next_wait;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_fast_tick;
        tick && !last && !modf && half == 7'h02;
    endsequence
    sequence s_stat_read_done;
        rd && hit(avs_address, SPP_STAT_OFS) && avs_readdata[SPP_ST_DONE];
    endsequence
    a_phase0_bit7: assert property (@(posedge core_clk) disable iff (!nrst)
        start && !ctrl[SPP_CTL_PHA] && !modf |=> mosi_o == $past(avs_writedata[7]))
        else $error("phase 0 did not present bit 7 before first edge");
    a_slave_quiet: assert property (@(posedge core_clk) disable iff (!nrst)
        !ctrl[SPP_CTL_MSTR] |-> !sck_oe && !mosi_oe)
        else $error("SCK driven while slave");
    a_rate_div4: assert property (@(posedge core_clk) disable iff (!nrst)
        s_fast_tick |=> !tick ##1 tick)
        else $error("half period not two clocks");
    a_done_set: assert property (@(posedge core_clk) disable iff (!nrst)
        last |=> done && rxbuf == $past(next_rx))
        else $error("done not set after last edge");
    a_irq_req: assert property (@(posedge core_clk) disable iff (!nrst)
        done && ctrl[SPP_CTL_IE] && global_irq_en |=> irq)
        else $error("interrupt not requested");
    a_modf_done: assert property (@(posedge core_clk) disable iff (!nrst)
        modf |=> done && !ctrl[SPP_CTL_MSTR] && state == SPP_IDLE)
        else $error("SS low did not flag done");
    a_vector_clr: assert property (@(posedge core_clk) disable iff (!nrst)
        vector_ack && !last && !modf |=> !done)
        else $error("vector did not clear done");
    a_seq_arm: assert property (@(posedge core_clk) disable iff (!nrst)
        s_stat_read_done |=> arm_done)
        else $error("status read did not arm the clear");
    a_seq_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        data_acc && arm_done && !last && !modf |=> !done)
        else $error("read-then-access did not clear done");
    a_write_collision_flag_set: assert property (@(posedge core_clk) disable iff (!nrst)
        collide && !last && !modf |=> write_collision_flag && busy)
        else $error("collision not flagged");
    a_write_collision_flag_clear: assert property (@(posedge core_clk) disable iff (!nrst)
        data_acc && arm_write_collision_flag && !collide && !last && !modf |=> !write_collision_flag && !done)
        else $error("collision sequence did not clear flags");
    a_start_shift: assert property (@(posedge core_clk) disable iff (!nrst)
        start && !modf |=> busy && edge_n == 5'h00 && sck_oe)
        else $error("idle write did not start a transfer");
endmodule

/* bench/spp_slave_model.sv */
`timescale 1ns/1ps
module spp_slave_model
(
    // Serial pins
    input wire logic sck,
    input wire logic mosi,
    output logic miso,
    // Frame control from the bench
    input wire logic active,
    input wire logic clock_polarity_select,
    input wire logic clock_phase_select,
    input wire logic [7:0] tx_byte,
    output logic [7:0] rx_byte
);
    logic [7:0] shift_out;

    initial
    begin
        miso = 1'b0;
        rx_byte = 8'h00;
        shift_out = 8'h00;
    end

    // Phase 0 needs the first bit in place before the leading edge
    always @(posedge active)
    begin
        shift_out = tx_byte;
        if (!clock_phase_select)
            miso = tx_byte[7];
    end

    // Released line must not keep showing the last bit
    always @(negedge active)
        miso = ~miso;

    // ------------------------------------------------------------
    // Sample on one SCK edge, set up on the other
    // ------------------------------------------------------------
    always @(sck)
    begin
        if (active && sck !== 1'bx)
        begin
            if ((sck != clock_polarity_select) == !clock_phase_select)
                rx_byte = {rx_byte[6:0], mosi};
            else if (clock_phase_select)
            begin
                miso = shift_out[7];
                shift_out = shift_out << 1;
            end
            else
            begin
                shift_out = shift_out << 1;
                miso = shift_out[7];
            end
        end
    end
endmodule

/* bench/spp_ctrl_bench.sv */
`timescale 1ns/1ps
module spp_ctrl_bench;
    import spp_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic core_clk, nrst, avs_read, avs_write, global_irq_en, vector_ack, ss_n;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic avs_waitrequest, irq, sck_o, sck_oe, mosi_o, mosi_oe, miso_i;
    logic slv_act, slv_pol, slv_pha;
    logic [7:0] slv_tx, slv_rx;
    wire sck_w;
    wire mosi_w;
    int num_errors = 0;
    int n_compared = 0;
    int cycles = 0;

    assign sck_w = sck_oe ? sck_o : slv_pol;
    assign mosi_w = mosi_oe ? mosi_o : 1'b1;

    spp_ctrl dut (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .global_irq_en(global_irq_en),
        .vector_ack(vector_ack), .irq(irq), .sck_o(sck_o), .sck_oe(sck_oe),
        .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_i), .ss_n(ss_n));

    spp_slave_model slave (.sck(sck_w), .mosi(mosi_w), .miso(miso_i), .active(slv_act),
        .clock_polarity_select(slv_pol), .clock_phase_select(slv_pha), .tx_byte(slv_tx), .rx_byte(slv_rx));

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Slowest run is well under this many cycles
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            num_errors++;
            results();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp, input string what);
        bus_rd(a, rd);
        chk(what, exp, rd);
    endtask

    task automatic wait_done();
        do bus_rd(SPP_STAT_OFS, rd); while (rd[7] !== 1'b1);
    endtask

    // SCK divisor halved: double speed halves it once more
    function automatic logic [31:0] exp_half(input logic dbl, input logic [1:0] rate);
        logic [31:0] div;
        case (rate)
            2'h0: div = 32'h04;
            2'h1: div = 32'h10;
            2'h2: div = 32'h40;
            default: div = 32'h80;
        endcase
        return dbl ? div >> 2 : div >> 1;
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd_chk(SPP_CTRL_OFS, 32'h0, "control after reset");
        rd_chk(SPP_STAT_OFS, 32'h0, "status after reset");
        rd_chk(SPP_IMSK_OFS, 32'h0, "mask after reset");
        bus_wr(5'h14, 8'hff);
        rd_chk(5'h14, 32'h0, "unmapped read");
        chk("sck drive after reset", 32'h0, {31'h0, sck_oe});
    endtask

    task automatic t_xfer(input logic dbl, input logic [1:0] rate, input logic [7:0] tx,
        input logic [7:0] stx);
        logic s;
        logic [31:0] n;
        slv_pha <= rate[0];
        slv_pol <= rate[1];
        slv_tx <= stx;
        bus_wr(SPP_STAT_OFS, {7'h00, dbl});
        bus_wr(SPP_CTRL_OFS, {4'h5, rate[1], rate[0], rate});
        // A polarity change moves SCK; the slave must not see it as an edge
        @(posedge core_clk);
        slv_act <= 1'b1;
        bus_wr(SPP_DATA_OFS, tx);
        n = 32'h0;
        s = sck_o;
        while (sck_o === s) @(posedge core_clk);
        s = sck_o;
        while (sck_o === s)
        begin
            @(posedge core_clk);
            n++;
        end
        chk("sck half period", exp_half(dbl, rate), n);
        wait_done();
        chk("status after transfer", {24'h0, 7'h40, dbl}, rd);
        rd_chk(SPP_DATA_OFS, {24'h0, stx}, "received byte");
        slv_act <= 1'b0;
        chk("slave received", {24'h0, tx}, {24'h0, slv_rx});
        rd_chk(SPP_STAT_OFS, {31'h0, dbl}, "done cleared");
    endtask

    task automatic t_collision();
        slv_pha <= 1'b0;
        slv_pol <= 1'b0;
        slv_tx <= 8'hc3;
        bus_wr(SPP_STAT_OFS, 8'h00);
        bus_wr(SPP_CTRL_OFS, 8'h53);
        @(posedge core_clk);
        slv_act <= 1'b1;
        bus_wr(SPP_DATA_OFS, 8'h96);
        bus_wr(SPP_DATA_OFS, 8'h0f);
        rd_chk(SPP_STAT_OFS, 32'h40, "collision flag");
        wait_done();
        chk("both flags", 32'hc0, rd);
        rd_chk(SPP_DATA_OFS, 32'hc3, "received byte");
        slv_act <= 1'b0;
        chk("dropped write", 32'h96, {24'h0, slv_rx});
        rd_chk(SPP_STAT_OFS, 32'h0, "flags cleared");
    endtask

    task automatic t_irq();
        bus_wr(SPP_IST_OFS, 8'h07);
        global_irq_en <= 1'b1;
        slv_tx <= 8'h11;
        bus_wr(SPP_CTRL_OFS, 8'hd0);
        slv_act <= 1'b1;
        bus_wr(SPP_DATA_OFS, 8'h22);
        wait_done();
        slv_act <= 1'b0;
        chk("irq with done", 32'h1, {31'h0, irq});
        global_irq_en <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("irq gated", 32'h0, {31'h0, irq});
        global_irq_en <= 1'b1;
        vector_ack <= 1'b1;
        @(posedge core_clk);
        vector_ack <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("irq after vector", 32'h0, {31'h0, irq});
        rd_chk(SPP_STAT_OFS, 32'h0, "done after vector");
        bus_wr(SPP_IMSK_OFS, 8'h01);
        repeat (2) @(posedge core_clk);
        chk("event irq", 32'h1, {31'h0, irq});
        rd_chk(SPP_IST_OFS, 32'h1, "event status");
        bus_wr(SPP_IST_OFS, 8'h01);
        repeat (2) @(posedge core_clk);
        chk("event cleared", 32'h0, {31'h0, irq});
    endtask

    task automatic t_fault();
        bus_wr(SPP_CTRL_OFS, 8'h50);
        ss_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        ss_n <= 1'b1;
        rd_chk(SPP_STAT_OFS, 32'h80, "done on fault");
        rd_chk(SPP_CTRL_OFS, 32'h40, "master dropped");
        rd_chk(SPP_IST_OFS, 32'h4, "fault event");
        bus_wr(SPP_IST_OFS, 8'h04);
        rd_chk(SPP_DATA_OFS, 32'h11, "data kept");
        bus_wr(SPP_DATA_OFS, 8'h77);
        repeat (20) @(posedge core_clk);
        chk("slave sck drive", 32'h0, {31'h0, sck_oe});
        chk("slave mosi drive", 32'h0, {31'h0, mosi_oe});
        rd_chk(SPP_STAT_OFS, 32'h0, "no slave transfer");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        global_irq_en = 1'b0;
        vector_ack = 1'b0;
        ss_n = 1'b1;
        slv_act = 1'b0;
        slv_pol = 1'b0;
        slv_pha = 1'b0;
        slv_tx = 8'h00;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        t_reset();
        for (int i = 0; i < 8; i++)
            t_xfer(i[2], i[1:0], 8'ha5 ^ i[7:0], 8'h3c + i[7:0]);
        t_collision();
        t_irq();
        t_fault();
        results();
    end
endmodule
